// File: src/spc_control.sv
// control and status register block of the audio serial port
`timescale 1ns/1ps
module spc_control
   import spc_pkg::*;
(
   input wire logic clock_i, // 50 MHz peripheral clock
   input wire logic resetn_i, // sync reset, active low
   input wire logic [7:0] reg_addr_i, // register byte address
   input wire logic [31:0] reg_wdata_i, // write data
   input wire logic reg_write_i, // write strobe
   input wire logic reg_read_i, // read strobe
   output logic [31:0] reg_rdata_o, // read data, cycle after strobe
   input wire logic emu_halt_i, // emulation halt, asynchronous
   input wire logic [7:0] rate_div_i, // generated clock half period - 1
   input wire logic [11:0] frame_period_i, // frame period - 1, in generated bit clocks
   input wire logic tx_busy_i, // transfer in progress
   input wire logic tx_shift_full_i, // tx shift register holds data
   input wire logic tx_data_free_i, // tx data register can take word
   input wire logic tx_sync_event_i, // tx sync error detected
   input wire logic tx_frame_sync_i, // tx frame sync level
   input wire logic tx_bit_i, // tx serial data
   input wire logic rx_word_load_i, // new word to data register
   input wire logic [31:0] rx_word_i, // raw received word
   input wire logic [5:0] rx_word_bits_i, // rx word length
   input wire logic rx_data_read_i, // data register was read
   input wire logic rx_buffer_full_i, // rx buffer register full
   input wire logic rx_shift_full_i, // rx shift register full
   input wire logic rx_sync_event_i, // rx sync error detected
   input wire logic rx_frame_sync_i, // rx new frame pulse
   input wire logic rx_clk_pin_i, // external rx clock pin
   input wire logic rx_fs_pin_i, // external rx frame pin
   input wire logic rx_dat_pin_i, // external rx data pin
   output logic generated_bit_clock_o, // generated bit clock
   output logic internal_frame_pulse_o, // internal frame pulse
   output logic serial_clk_run_o, // serial clocks running
   output logic tx_enable_o, // transmitter enabled
   output logic rx_enable_o, // receiver enabled
   output logic tx_irq_o, // transmit interrupt
   output logic rx_irq_o, // receive interrupt
   output logic rx_bit_clk_rise_o, // rx clock rising edge pulse
   output logic rx_frame_o, // selected rx frame level
   output logic rx_bit_o, // selected rx data bit
   output logic [31:0] rx_data_reg_o // formatted rx word
);
   logic free_reg, soft_reg, frame_gen_reset_n, rate_gen_reset_n;
   logic [1:0] tx_irq_select, rx_irq_select, rx_justify_mode;
   logic tx_reset_n, rx_reset_n, loopback_enable;
   logic tx_sync_error, rx_sync_error;
   logic tx_shift_empty_n, tx_ready_flag, rx_ready_flag, rx_overrun_flag;
   logic halt_meta, halt_s, soft_hold_reg;
   logic [7:0] rate_cnt_reg;
   logic [11:0] frame_cnt_reg;
   logic [2:0] pin_meta, pin_s;
   logic rx_clk_prev;
   logic ctrl_wr, gclk_rise, rx_clk_sel;
   logic [31:0] ctrl_image;

   assign ctrl_wr = reg_write_i && (reg_addr_i == SPC_CTRL_OFFSET);

   // control fields; reserved bits including bit 7 are never stored
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         free_reg <= SPC_CTRL_RESET[SPC_FREE_BIT];
         soft_reg <= SPC_CTRL_RESET[SPC_SOFT_BIT];
         frame_gen_reset_n <= SPC_CTRL_RESET[SPC_FRAME_RST_BIT];
         rate_gen_reset_n <= SPC_CTRL_RESET[SPC_RATE_RST_BIT];
         tx_irq_select <= SPC_CTRL_RESET[SPC_TXM_LO+:2];
         tx_reset_n <= SPC_CTRL_RESET[SPC_TXRST_BIT];
         loopback_enable <= SPC_CTRL_RESET[SPC_LOOP_BIT];
         rx_justify_mode <= SPC_CTRL_RESET[SPC_JUSTIFY_LO+:2];
         rx_irq_select <= SPC_CTRL_RESET[SPC_RXM_LO+:2];
         rx_reset_n <= SPC_CTRL_RESET[SPC_RXRST_BIT];
      end
      else if (ctrl_wr)
      begin
         free_reg <= reg_wdata_i[SPC_FREE_BIT];
         soft_reg <= reg_wdata_i[SPC_SOFT_BIT];
         frame_gen_reset_n <= reg_wdata_i[SPC_FRAME_RST_BIT];
         rate_gen_reset_n <= reg_wdata_i[SPC_RATE_RST_BIT];
         tx_irq_select <= reg_wdata_i[SPC_TXM_LO+:2];
         tx_reset_n <= reg_wdata_i[SPC_TXRST_BIT];
         loopback_enable <= reg_wdata_i[SPC_LOOP_BIT];
         rx_justify_mode <= reg_wdata_i[SPC_JUSTIFY_LO+:2];
         rx_irq_select <= reg_wdata_i[SPC_RXM_LO+:2];
         rx_reset_n <= reg_wdata_i[SPC_RXRST_BIT];
      end
   end

   assign tx_enable_o = tx_reset_n;
   assign rx_enable_o = rx_reset_n;

   // sync errors: hardware set wins over a software clear
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || !tx_reset_n)
         tx_sync_error <= 1'b0;
      else if (tx_sync_event_i ||
               (ctrl_wr && reg_wdata_i[SPC_TXERR_BIT]))
         tx_sync_error <= 1'b1;
      else if (ctrl_wr)
         tx_sync_error <= 1'b0;
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || !rx_reset_n)
         rx_sync_error <= 1'b0;
      else if (rx_sync_event_i || (ctrl_wr && reg_wdata_i[SPC_RXERR_BIT]))
         rx_sync_error <= 1'b1;
      else if (ctrl_wr)
         rx_sync_error <= 1'b0;
   end

   // read-only flags follow hardware only
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || !tx_reset_n)
      begin
         tx_shift_empty_n <= 1'b0;
         tx_ready_flag <= 1'b0;
      end
      else
      begin
         tx_shift_empty_n <= tx_shift_full_i;
         tx_ready_flag <= tx_data_free_i;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || !rx_reset_n)
         rx_ready_flag <= 1'b0;
      else if (rx_word_load_i)
         rx_ready_flag <= 1'b1;
      else if (rx_data_read_i)
         rx_ready_flag <= 1'b0;
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || !rx_reset_n)
         rx_overrun_flag <= 1'b0;
      else
         rx_overrun_flag <= rx_ready_flag && rx_buffer_full_i &&
                            rx_shift_full_i;
   end

   spc_rx_justify u_justify (
      .clock_i (clock_i),
      .resetn_i (resetn_i),
      .load_i (rx_word_load_i && rx_reset_n),
      .raw_i (rx_word_i),
      .bits_i (rx_word_bits_i),
      .mode_i (rx_justify_mode),
      .word_o (rx_data_reg_o)
   );

   // emulation halt comes from another domain
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         halt_meta <= 1'b0;
         halt_s <= 1'b0;
      end
      else
      begin
         halt_meta <= emu_halt_i;
         halt_s <= halt_meta;
      end
   end

   // once the transfer ends under halt, stay stopped until halt drops
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || !halt_s)
         soft_hold_reg <= 1'b1;
      else if (!tx_busy_i)
         soft_hold_reg <= 1'b0;
   end

   assign serial_clk_run_o = free_reg || !halt_s ||
                             (soft_reg && soft_hold_reg);

   // rate generator
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || !rate_gen_reset_n)
      begin
         rate_cnt_reg <= 8'h00;
         generated_bit_clock_o <= 1'b0;
      end
      else if (serial_clk_run_o)
      begin
         if (rate_cnt_reg == 8'h00)
         begin
            rate_cnt_reg <= rate_div_i;
            generated_bit_clock_o <= ~generated_bit_clock_o;
         end
         else
            rate_cnt_reg <= rate_cnt_reg - 8'h01;
      end
   end

   assign gclk_rise = rate_gen_reset_n && serial_clk_run_o &&
                      (rate_cnt_reg == 8'h00) && !generated_bit_clock_o;

   // frame counter loads frame_period, pulses on the next bit clock rise after it hits 0
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i || !frame_gen_reset_n || !rate_gen_reset_n)
      begin
         frame_cnt_reg <= frame_period_i;
         internal_frame_pulse_o <= 1'b0;
      end
      else if (gclk_rise)
      begin
         internal_frame_pulse_o <= (frame_cnt_reg == 12'h000);
         frame_cnt_reg <= (frame_cnt_reg == 12'h000) ? frame_period_i :
                          frame_cnt_reg - 12'h001;
      end
      else
         internal_frame_pulse_o <= 1'b0;
   end

   // interrupt selection; reserved code gives no interrupt
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         tx_irq_o <= 1'b0;
         rx_irq_o <= 1'b0;
      end
      else
      begin
         unique case (tx_irq_select)
            SPC_IRQ_READY: tx_irq_o <= tx_ready_flag;
            SPC_IRQ_FRAME: tx_irq_o <= tx_frame_sync_i;
            SPC_IRQ_ERROR: tx_irq_o <= tx_sync_error;
            default: tx_irq_o <= 1'b0;
         endcase
         unique case (rx_irq_select)
            SPC_IRQ_READY: rx_irq_o <= rx_ready_flag;
            SPC_IRQ_FRAME: rx_irq_o <= rx_frame_sync_i;
            SPC_IRQ_ERROR: rx_irq_o <= rx_sync_error;
            default: rx_irq_o <= 1'b0;
         endcase
      end
   end

   // rx pins pass two flops; loopback bypasses them entirely
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         pin_meta <= 3'h0;
         pin_s <= 3'h0;
      end
      else
      begin
         pin_meta <= {rx_clk_pin_i, rx_fs_pin_i, rx_dat_pin_i};
         pin_s <= pin_meta;
      end
   end

   assign rx_clk_sel = loopback_enable ? generated_bit_clock_o : pin_s[2];

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         rx_clk_prev <= 1'b0;
         rx_bit_clk_rise_o <= 1'b0;
         rx_frame_o <= 1'b0;
         rx_bit_o <= 1'b0;
      end
      else
      begin
         rx_clk_prev <= rx_clk_sel;
         rx_bit_clk_rise_o <= rx_clk_sel && !rx_clk_prev;
         rx_frame_o <= loopback_enable ? tx_frame_sync_i : pin_s[1];
         rx_bit_o <= loopback_enable ? tx_bit_i : pin_s[0];
      end
   end

   always_comb
   begin
      ctrl_image = 32'h0000_0000;
      ctrl_image[SPC_FREE_BIT] = free_reg;
      ctrl_image[SPC_SOFT_BIT] = soft_reg;
      ctrl_image[SPC_FRAME_RST_BIT] = frame_gen_reset_n;
      ctrl_image[SPC_RATE_RST_BIT] = rate_gen_reset_n;
      ctrl_image[SPC_TXM_LO+:2] = tx_irq_select;
      ctrl_image[SPC_TXERR_BIT] = tx_sync_error;
      ctrl_image[SPC_TXEMPTY_BIT] = tx_shift_empty_n;
      ctrl_image[SPC_TXRDY_BIT] = tx_ready_flag;
      ctrl_image[SPC_TXRST_BIT] = tx_reset_n;
      ctrl_image[SPC_LOOP_BIT] = loopback_enable;
      ctrl_image[SPC_JUSTIFY_LO+:2] = rx_justify_mode;
      ctrl_image[SPC_RXM_LO+:2] = rx_irq_select;
      ctrl_image[SPC_RXERR_BIT] = rx_sync_error;
      ctrl_image[SPC_RXFULL_BIT] = rx_overrun_flag;
      ctrl_image[SPC_RXRDY_BIT] = rx_ready_flag;
      ctrl_image[SPC_RXRST_BIT] = rx_reset_n;
   end

   // unmapped reads return zero; data stands one cycle only
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
         reg_rdata_o <= 32'h0000_0000;
      else if (reg_read_i && reg_addr_i == SPC_CTRL_OFFSET)
         reg_rdata_o <= ctrl_image;
      else
         reg_rdata_o <= 32'h0000_0000;
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   a_free_clock_run: assert property (free_reg |-> serial_clk_run_o)
      else $error("clock stopped in run-on mode");
   a_hard_halt_stop: assert property (
      (halt_s && !free_reg && !soft_reg) |-> !serial_clk_run_o)
      else $error("clock ran during hard halt");
   a_soft_halt_wait: assert property (
      (!free_reg && soft_reg && $rose(halt_s) && tx_busy_i)
      |-> serial_clk_run_o)
      else $error("graceful halt cut transfer");
   a_frame_held_off: assert property (
      !$past(frame_gen_reset_n) |-> !internal_frame_pulse_o)
      else $error("frame pulse while frame reset");
   a_rate_held_off: assert property (
      !$past(rate_gen_reset_n) |-> !generated_bit_clock_o)
      else $error("generated clock while rate reset");
   a_tx_err_write: assert property (
      (ctrl_wr && reg_wdata_i[SPC_TXERR_BIT] && tx_reset_n &&
       reg_wdata_i[SPC_TXRST_BIT]) |=> tx_sync_error)
      else $error("write one did not set tx sync error");
   a_tx_irq_error: assert property (
      ($past(tx_irq_select) == SPC_IRQ_ERROR)
      |-> (tx_irq_o == $past(tx_sync_error)))
      else $error("tx irq not following sync error");
   a_rx_ready_set: assert property (
      (rx_word_load_i && rx_reset_n && !(ctrl_wr &&
       !reg_wdata_i[SPC_RXRST_BIT])) |=> rx_ready_flag)
      else $error("rx ready not set on word load");
   a_loop_data_route: assert property (
      $past(loopback_enable) |-> (rx_bit_o == $past(tx_bit_i)))
      else $error("loopback data not routed");
   a_reserved_read_zero: assert property (
      reg_read_i |=> (reg_rdata_o[31:26] == 6'h00 &&
                      reg_rdata_o[12:6] == 7'h00))
      else $error("reserved bits read nonzero");

   c_frame_pulse: cover property (internal_frame_pulse_o);
   c_soft_stop: cover property (halt_s && soft_reg && !serial_clk_run_o);
   c_loop_edge: cover property (loopback_enable && rx_bit_clk_rise_o);
   c_tx_irq: cover property (tx_irq_o && tx_irq_select == SPC_IRQ_ERROR);
endmodule

// File: src/spc_pkg.sv
// constants for the serial port control and status block
package spc_pkg;
   localparam logic [7:0] SPC_CTRL_OFFSET = 8'h00;
   localparam logic [31:0] SPC_CTRL_RESET = 32'h0000_0000;
   localparam int SPC_FREE_BIT = 25;
   localparam int SPC_SOFT_BIT = 24;
   localparam int SPC_FRAME_RST_BIT = 23;
   localparam int SPC_RATE_RST_BIT = 22;
   localparam int SPC_TXM_LO = 20;
   localparam int SPC_TXERR_BIT = 19;
   localparam int SPC_TXEMPTY_BIT = 18;
   localparam int SPC_TXRDY_BIT = 17;
   localparam int SPC_TXRST_BIT = 16;
   localparam int SPC_LOOP_BIT = 15;
   localparam int SPC_JUSTIFY_LO = 13;
   localparam int SPC_RXM_LO = 4;
   localparam int SPC_RXERR_BIT = 3;
   localparam int SPC_RXFULL_BIT = 2;
   localparam int SPC_RXRDY_BIT = 1;
   localparam int SPC_RXRST_BIT = 0;
   localparam logic [1:0] SPC_IRQ_READY = 2'h0;
   localparam logic [1:0] SPC_IRQ_FRAME = 2'h2;
   localparam logic [1:0] SPC_IRQ_ERROR = 2'h3;
   localparam logic [1:0] SPC_JUST_RZERO = 2'h0;
   localparam logic [1:0] SPC_JUST_RSIGN = 2'h1;
   localparam logic [1:0] SPC_JUST_LZERO = 2'h2;
endpackage

// File: src/spc_rx_justify.sv
// formats a received word for the receive data register
`timescale 1ns/1ps
module spc_rx_justify
   import spc_pkg::*;
(
   input wire logic clock_i, // peripheral clock
   input wire logic resetn_i, // sync reset, active low
   input wire logic load_i, // capture a new word
   input wire logic [31:0] raw_i, // right-aligned raw bits
   input wire logic [5:0] bits_i, // word length, 1 to 32
   input wire logic [1:0] mode_i, // justification mode
   output logic [31:0] word_o // formatted word
);
   logic [31:0] mask;
   logic [31:0] low;
   logic [31:0] fmt;
   logic sign;
   logic [5:0] left_shift;

   always_comb
   begin
      mask = (bits_i >= 6'h20) ? 32'hFFFF_FFFF :
             ((32'h0000_0001 << bits_i) - 32'h0000_0001);
      low = raw_i & mask;
      sign = (bits_i == 6'h00) ? 1'b0 : raw_i[5'(bits_i - 6'h01)];
      left_shift = 6'h20 - bits_i;
      unique case (mode_i)
         SPC_JUST_RSIGN: fmt = sign ? (low | ~mask) : low;
         SPC_JUST_LZERO: fmt = low << left_shift;
         // reserved code falls back to plain right-justify
         default: fmt = low;
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
         word_o <= 32'h0000_0000;
      else if (load_i)
         word_o <= fmt;
   end
endmodule

// File: test/spc_codec_model.sv
// behavioural serial audio source on the receive pins
`timescale 1ns/1ps
module spc_codec_model
(
   input wire logic start_i, // rising edge sends one frame
   input wire logic [7:0] word_i, // word sent msb first
   output logic clk_o, // bit clock, still between frames
   output logic fs_o, // frame sync, high on first bit
   output logic dat_o // serial data
);
   initial
   begin
      clk_o = 1'b0;
      fs_o = 1'b0;
      dat_o = 1'b0;
   end
   always @(posedge start_i)
   begin
      // odd offset keeps the link unrelated to the block clock
      #7;
      for (int i = 7; i >= 0; i--)
      begin
         dat_o = word_i[i];
         fs_o = (i == 7);
         #80 clk_o = 1'b1;
         #80 clk_o = 1'b0;
      end
      fs_o = 1'b0;
      // line released: inverse, so a stale bit cannot pass
      dat_o = ~dat_o;
   end
endmodule

// File: test/tb_top.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module tb_top;
   logic clock_i, resetn_i, reg_write_i, reg_read_i, emu_halt_i;
   logic [7:0] reg_addr_i, rate_div_i, codec_word;
   logic [31:0] reg_wdata_i, reg_rdata_o, rx_word_i, rx_data_reg_o, d;
   logic [11:0] frame_period_i;
   logic [5:0] rx_word_bits_i;
   logic tx_busy_i, tx_shift_full_i, tx_data_free_i, tx_sync_event_i;
   logic tx_frame_sync_i, tx_bit_i, rx_word_load_i, rx_data_read_i;
   logic rx_buffer_full_i, rx_shift_full_i, rx_sync_event_i;
   logic rx_frame_sync_i, rx_clk_pin_i, rx_fs_pin_i, rx_dat_pin_i;
   logic generated_bit_clock_o, internal_frame_pulse_o, serial_clk_run_o;
   logic tx_enable_o, rx_enable_o, tx_irq_o, rx_irq_o, rx_bit_clk_rise_o;
   logic rx_frame_o, rx_bit_o, codec_start, prev;
   int miscompares = 0;
   int tests_run = 0;
   int s, m, n, h, k;
   logic [31:0] just_exp [4] = '{32'h000000A5, 32'hFFFFFFA5,
      32'hA5000000, 32'h000000A5};

   spc_control dut (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_write_i(reg_write_i),
      .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o),
      .emu_halt_i(emu_halt_i),
      .rate_div_i(rate_div_i),
      .frame_period_i(frame_period_i),
      .tx_busy_i(tx_busy_i),
      .tx_shift_full_i(tx_shift_full_i),
      .tx_data_free_i(tx_data_free_i),
      .tx_sync_event_i(tx_sync_event_i),
      .tx_frame_sync_i(tx_frame_sync_i),
      .tx_bit_i(tx_bit_i),
      .rx_word_load_i(rx_word_load_i),
      .rx_word_i(rx_word_i),
      .rx_word_bits_i(rx_word_bits_i),
      .rx_data_read_i(rx_data_read_i),
      .rx_buffer_full_i(rx_buffer_full_i),
      .rx_shift_full_i(rx_shift_full_i),
      .rx_sync_event_i(rx_sync_event_i),
      .rx_frame_sync_i(rx_frame_sync_i),
      .rx_clk_pin_i(rx_clk_pin_i),
      .rx_fs_pin_i(rx_fs_pin_i),
      .rx_dat_pin_i(rx_dat_pin_i),
      .generated_bit_clock_o(generated_bit_clock_o),
      .internal_frame_pulse_o(internal_frame_pulse_o),
      .serial_clk_run_o(serial_clk_run_o),
      .tx_enable_o(tx_enable_o),
      .rx_enable_o(rx_enable_o),
      .tx_irq_o(tx_irq_o),
      .rx_irq_o(rx_irq_o),
      .rx_bit_clk_rise_o(rx_bit_clk_rise_o),
      .rx_frame_o(rx_frame_o),
      .rx_bit_o(rx_bit_o),
      .rx_data_reg_o(rx_data_reg_o)
   );
   spc_codec_model codec (
      .start_i(codec_start),
      .word_i(codec_word),
      .clk_o(rx_clk_pin_i),
      .fs_o(rx_fs_pin_i),
      .dat_o(rx_dat_pin_i)
   );

   always #10 clock_i = ~clock_i;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_i);
      reg_write_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge clock_i);
      reg_write_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock_i);
      reg_read_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_read_i <= 1'b0;
      // data stands one cycle only, so take it mid-cycle
      @(negedge clock_i);
      d = reg_rdata_o;
   endtask
   task automatic pk(input int c);
      repeat (c) @(posedge clock_i);
      @(negedge clock_i);
   endtask
   task automatic ld(input logic [31:0] w);
      @(posedge clock_i);
      rx_word_i <= w;
      rx_word_load_i <= 1'b1;
      @(posedge clock_i);
      rx_word_load_i <= 1'b0;
   endtask
   task automatic cnt(input int c);
      n = 0;
      k = 0;
      repeat (c)
      begin
         @(negedge clock_i);
         if (generated_bit_clock_o !== 1'b0) n++;
         if (internal_frame_pulse_o !== 1'b0) k++;
      end
   endtask
   // counts rx clock rise pulses and shifts in the bit beside each
   task automatic rises(input int c);
      n = 0;
      d = 32'h0000_0000;
      repeat (c)
      begin
         @(negedge clock_i);
         if (rx_bit_clk_rise_o === 1'b1)
         begin
            n++;
            d = {d[30:0], rx_bit_o};
         end
      end
   endtask
   task complete_run;
      if (miscompares == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge clock_i);
      miscompares++;
      complete_run;
   end

   initial
   begin
      {clock_i, resetn_i, reg_write_i, reg_read_i, emu_halt_i} = '0;
      {reg_addr_i, reg_wdata_i, rx_word_i, codec_start} = '0;
      {tx_busy_i, tx_shift_full_i, tx_data_free_i, tx_sync_event_i} = '0;
      {tx_frame_sync_i, tx_bit_i, rx_word_load_i, rx_data_read_i} = '0;
      {rx_buffer_full_i, rx_shift_full_i, rx_sync_event_i} = '0;
      rx_frame_sync_i = 1'b0;
      rate_div_i = 8'h03;
      frame_period_i = 12'h003;
      rx_word_bits_i = 6'h08;
      codec_word = 8'hC5;
      repeat (10) @(posedge clock_i);
      resetn_i <= 1'b1;
      rd(8'h00);
      chk(d, 32'h00000000);
      wr(8'h04, 32'hFFFFFF7F);
      rd(8'h04);
      chk(d, 32'h00000000);
      wr(8'h00, 32'hFFFFFF7F);
      rd(8'h00);
      chk(d, 32'h03F1E031);
      wr(8'h00, 32'hFFFFFF7F);
      rd(8'h00);
      chk(d, 32'h03F9E039);
      chk({tx_enable_o, rx_enable_o}, 2'b11);
      wr(8'h00, 32'h00010001);
      @(posedge clock_i);
      {tx_shift_full_i, rx_buffer_full_i, rx_shift_full_i} <= 3'b111;
      ld(32'h00000001);
      rd(8'h00);
      chk(d, 32'h00050007);
      @(posedge clock_i);
      {tx_data_free_i, rx_data_read_i} <= 2'b11;
      @(posedge clock_i);
      rx_data_read_i <= 1'b0;
      rd(8'h00);
      chk(d, 32'h00070001);
      wr(8'h00, 32'h00000000);
      rd(8'h00);
      chk(d, 32'h00000000);
      wr(8'h00, 32'h00010001);
      for (s = 0; s < 4; s++)
         for (m = 0; m < 4; m++)
         begin
            @(posedge clock_i);
            rx_data_read_i <= 1'b1;
            tx_data_free_i <= (s == 0);
            tx_frame_sync_i <= (s == 2);
            rx_frame_sync_i <= (s == 2);
            @(posedge clock_i);
            rx_data_read_i <= 1'b0;
            wr(8'h00, 32'h00010001 | (m << 20) | (m << 4));
            if (s == 0) ld(32'h00000001);
            @(posedge clock_i);
            {tx_sync_event_i, rx_sync_event_i} <= {2{s == 3}};
            @(posedge clock_i);
            {tx_sync_event_i, rx_sync_event_i} <= 2'b00;
            pk(3);
            chk(tx_irq_o, (m == s) && (s != 1));
            chk(rx_irq_o, (m == s) && (s != 1));
         end
      for (m = 0; m < 4; m++)
      begin
         wr(8'h00, 32'h00010001 | (m << 13));
         ld(32'h000000A5);
         pk(2);
         chk(rx_data_reg_o, just_exp[m]);
      end
      wr(8'h00, 32'h00000000);
      ld(32'h0000005A);
      pk(2);
      chk(rx_data_reg_o, 32'h000000A5);
      cnt(20);
      chk(n, 0);
      wr(8'h00, 32'h00400000);
      cnt(60);
      chk(k, 0);
      chk(n != 0, 1'b1);
      wr(8'h00, 32'h00000000);
      wr(8'h00, 32'h00C00000);
      {n, h, k} = '0;
      prev = 1'b0;
      while (internal_frame_pulse_o !== 1'b1 && k < 400)
      begin
         @(negedge clock_i);
         if (generated_bit_clock_o === 1'b1 && prev === 1'b0) n++;
         if (generated_bit_clock_o === 1'b1 && n == 1) h++;
         prev = generated_bit_clock_o;
         k++;
      end
      chk(n, frame_period_i + 1);
      chk(h, rate_div_i + 1);
      wr(8'h00, 32'h01000000);
      @(posedge clock_i);
      {emu_halt_i, tx_busy_i} <= 2'b11;
      pk(6);
      chk(serial_clk_run_o, 1'b1);
      @(posedge clock_i);
      tx_busy_i <= 1'b0;
      pk(4);
      chk(serial_clk_run_o, 1'b0);
      wr(8'h00, 32'h03000000);
      pk(2);
      chk(serial_clk_run_o, 1'b1);
      wr(8'h00, 32'h00000000);
      @(posedge clock_i);
      tx_busy_i <= 1'b1;
      pk(4);
      chk(serial_clk_run_o, 1'b0);
      @(posedge clock_i);
      {emu_halt_i, tx_busy_i} <= 2'b00;
      pk(4);
      chk(serial_clk_run_o, 1'b1);
      wr(8'h00, 32'h00408001);
      @(posedge clock_i);
      {tx_frame_sync_i, tx_bit_i} <= 2'b11;
      pk(6);
      chk({rx_frame_o, rx_bit_o}, 2'b11);
      // generated clock half period is 4 cycles: 4 rises in 32 cycles
      rises(32);
      chk(n, 4);
      wr(8'h00, 32'h00400001);
      pk(6);
      chk({rx_frame_o, rx_bit_o}, 2'b00);
      @(posedge clock_i);
      codec_start <= 1'b1;
      rises(120);
      chk(n, 8);
      chk(d, 32'h000000C5);
      complete_run;
   end
endmodule
